// ---- srb_cfg.svh ----
// offsets, field positions, reset values and counts of the serial receive block
`ifndef SRB_CFG_SVH
`define SRB_CFG_SVH
`define SRB_OFF_CTRL      8'h08
`define SRB_OFF_ST1       8'h10
`define SRB_OFF_ST2       8'h14
`define SRB_OFF_DATA      8'h18
`define SRB_OFF_BAUD      8'h1c
`define SRB_RESP_OKAY     2'h0
`define SRB_RESP_SLVERR   2'h2
`define SRB_BAUD_PRE_LSB  4
`define SRB_BAUD_RATE_LSB 0
`define SRB_CTRL_RST      7'h00
`define SRB_BAUD_RST      5'h00
`define SRB_FLAGS_RST     5'h00
`define SRB_PD_00         4'h1
`define SRB_PD_01         4'h3
`define SRB_PD_10         4'h4
`define SRB_PD_11         4'hd
// source ticks per 16x sample at divisor one (64 / 16)
`define SRB_BD_BASE       10'h004
`define SRB_SLOT_A        4'h7
`define SRB_SLOT_C        4'h9
`define SRB_SLOT_LAST     4'hf
`define SRB_OS_LAST       4'hf
`define SRB_DATA_BITS     4'h8
// ten bit times of sixteen slots
`define SRB_IDLE_TICKS    8'ha0
`endif

// ---- srb_pkg.sv ----
// types of the serial receive status and baud block
package srb_pkg;
    typedef enum logic [1:0] {RX_SEARCH, RX_START, RX_DATA, RX_STOP} srb_rx_state_t;
    typedef enum logic [2:0] {SEL_NONE, SEL_CTRL, SEL_ST1, SEL_ST2, SEL_DATA, SEL_BAUD} srb_sel_t;
    typedef struct packed {
        logic receive_full_flag; logic ovr; logic nf; logic fe; logic pe;
    } srb_flags_t;
    typedef struct packed {
        logic par_odd; logic par_en; logic nine_mode;
        logic overrun_irq_enable; logic noise_irq_enable; logic framing_irq_enable; logic parity_irq_enable;
    } srb_ctrl_t;
    typedef struct packed {
        logic [1:0] prescale; logic [2:0] rate;
    } srb_baud_t;
    typedef struct packed {
        logic rx_meta; logic rx_s; logic xt_meta; logic xt_s; logic xt_d;
        logic src_meta; logic src_s;
        logic awready; logic wready; logic aw_ok; logic w_ok;
        logic [7:0] awaddr; logic [7:0] wdata; logic wlane;
        logic bvalid; logic [1:0] bresp;
        logic arready; logic rvalid; logic [7:0] rdata; logic [1:0] rresp;
        srb_ctrl_t ctrl; srb_baud_t baud; srb_flags_t flags; srb_flags_t arm;
        logic break_flag; logic bkf_arm; logic brk_block; logic reception_active_flag;
        logic [7:0] rx_data; logic ninth;
        srb_rx_state_t rxs; logic [3:0] slot; logic [3:0] bit_idx;
        logic [9:0] shreg; logic [2:0] samp; logic noisy; logic anyone;
        logic [7:0] idle_cnt;
        logic [7:0] tx_data; logic tx_load; logic irq;
    } srb_state_t;
    typedef struct packed {
        logic [3:0] pd_cnt; logic [9:0] bd_cnt; logic [3:0] os_cnt;
        logic rx16; logic bit_tick;
    } srb_bg_state_t;
endpackage

// ---- srb_baud_gen.sv ----
// prescaler and power-of-two divider giving the 16x sample tick and the bit tick
`timescale 1ns/1ps
`default_nettype none
`include "srb_cfg.svh"
module srb_baud_gen (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       src_tick,
    input  wire logic [1:0] prescale,
    input  wire logic [2:0] rate,
    output logic            rx16_tick,
    output logic            bit_tick
);
    srb_pkg::srb_bg_state_t st_reg;
    srb_pkg::srb_bg_state_t st_next;
    logic [3:0]             pd_last;
    logic [9:0]             bd_last;

    function automatic logic [3:0] pd_div(input logic [1:0] code);
        if (code == 2'h0) return `SRB_PD_00;
        else if (code == 2'h1) return `SRB_PD_01;
        else if (code == 2'h2) return `SRB_PD_10;
        else return `SRB_PD_11;
    endfunction

    always_comb begin
        st_next = st_reg;
        pd_last = pd_div(prescale) - 4'h1; // RULE_16
        bd_last = (`SRB_BD_BASE << rate) - 10'h001; // RULE_17
        st_next.rx16 = 1'b0;
        st_next.bit_tick = 1'b0;
        // compare with >= so a divisor lowered mid-count recovers at once
        if (src_tick) begin
            if (st_reg.pd_cnt >= pd_last) begin
                st_next.pd_cnt = 4'h0;
                if (st_reg.bd_cnt >= bd_last) begin
                    st_next.bd_cnt = 10'h000;
                    st_next.rx16 = 1'b1; // RULE_25
                    st_next.os_cnt = st_reg.os_cnt + 4'h1;
                    st_next.bit_tick = (st_reg.os_cnt == `SRB_OS_LAST); // RULE_18
                end else begin
                    st_next.bd_cnt = st_reg.bd_cnt + 10'h001;
                end
            end else begin
                st_next.pd_cnt = st_reg.pd_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rx16_tick = st_reg.rx16;
    assign bit_tick  = st_reg.bit_tick;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_pd_wrap; src_tick && st_reg.pd_cnt >= pd_last |=> st_reg.pd_cnt == 4'h0; endproperty
    a_pd_wrap: assert property (p_pd_wrap) else $error("prescaler did not wrap"); // RULE_16
    property p_bd_wrap; st_reg.rx16 |-> st_reg.bd_cnt == 10'h000 && st_reg.pd_cnt == 4'h0; endproperty
    a_bd_wrap: assert property (p_bd_wrap) else $error("rate divider not wrapped at tick"); // RULE_17
    property p_bit; st_reg.bit_tick |-> st_reg.rx16 && st_reg.os_cnt == 4'h0; endproperty
    a_bit: assert property (p_bit) else $error("bit tick not on sixteenth sample tick"); // RULE_18
endmodule // srb_baud_gen
`default_nettype wire

// ---- srb_sci_rx.sv ----
// serial receiver flags, data buffer and baud select behind an axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01: new character while receive full still set raises the overrun flag.
// RULE_02: on overrun the new character is dropped, buffer keeps its byte.
// RULE_03: error interrupt is any of overrun, noise, framing, parity with enables.
// RULE_04: status one read with flag set, then buffer read, clears that flag.
// RULE_05: overrun set after the status read survives the following buffer read.
// RULE_06: noise on the input sets noise flag; status read then buffer read clears.
// RULE_07: a low stop bit sets the framing error flag.
// RULE_08: failing parity check sets the parity error flag.
// RULE_09: reset clears overrun, noise, framing and parity flags.
// RULE_10: break sets break, framing and full flags; ninth bit forced low.
// RULE_11: break flag raises no interrupt; status two then buffer read clears it.
// RULE_12: break flag re-arms only after the line has been seen high again.
// RULE_13: low sample at start of start-bit search sets reception active.
// RULE_14: false start or idle line clears reception active; it never interrupts.
// RULE_15: buffer read gives received byte, write loads transmit byte, reset keeps it; here reset keeps rx_data but clears tx_data.
// RULE_16: prescale code 00,01,10,11 divides by 1,3,4,13.
// RULE_17: rate code n divides by two to the power n.
// RULE_18: baud is source over 64 times both divisors, shared by both directions.
// RULE_19: source is bus clock or crystal clock by an outside select bit.
// RULE_20: reset clears prescale and rate fields.
// RULE_21: software must not read-modify-write the buffer; reads pop, writes queue.
// RULE_22: software may reread status one after the buffer to catch late overrun.
// RULE_23: moving a character into the buffer sets receive full.
// RULE_24: ninth bit is captured together with the buffer byte.
// RULE_25: baud generator also gives a sixteen-times sampling tick.
`include "srb_cfg.svh"
module srb_sci_rx (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rxd,
    input  wire logic        crystal_clock,
    input  wire logic        baud_clock_source_select,
    output logic             error_irq,
    output logic [7:0]       tx_data,
    output logic             tx_load,
    output logic             tx_bit_tick
);
    srb_pkg::srb_state_t st_reg;
    srb_pkg::srb_state_t st_next;
    srb_pkg::srb_sel_t   wsel;
    srb_pkg::srb_sel_t   rsel;
    logic                src_tick;
    logic                rx16_tick;
    logic                data_rd;
    logic                frame_done;
    logic                stop_bit;
    logic                maj;
    logic                nz;
    logic                brk;
    logic [3:0]          nbits;

    function automatic srb_pkg::srb_sel_t reg_sel(input logic [7:0] a);
        if (a == `SRB_OFF_CTRL) return srb_pkg::SEL_CTRL;
        else if (a == `SRB_OFF_ST1) return srb_pkg::SEL_ST1;
        else if (a == `SRB_OFF_ST2) return srb_pkg::SEL_ST2;
        else if (a == `SRB_OFF_DATA) return srb_pkg::SEL_DATA;
        else if (a == `SRB_OFF_BAUD) return srb_pkg::SEL_BAUD;
        else return srb_pkg::SEL_NONE;
    endfunction

    function automatic logic maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // parity bit sits last; even parity wants the xor of all bits low
    function automatic logic par_bad(input logic [9:0] s, input logic [3:0] n,
                                     input logic odd);
        logic acc;
        acc = odd;
        for (int i = 0; i < 10; i++) begin
            if (4'(i) < n) acc = acc ^ s[i];
        end
        return acc;
    endfunction

    // crystal edges count only below half the bus clock rate
    assign src_tick = st_reg.src_s ? (st_reg.xt_s & ~st_reg.xt_d) : 1'b1; // RULE_19

    srb_baud_gen u_baud (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .src_tick  (src_tick),
        .prescale  (st_reg.baud.prescale),
        .rate      (st_reg.baud.rate),
        .rx16_tick (rx16_tick),
        .bit_tick  (tx_bit_tick)
    );

    always_comb begin
        st_next = st_reg;
        wsel = srb_pkg::SEL_NONE;
        rsel = srb_pkg::SEL_NONE;
        data_rd = 1'b0;
        frame_done = 1'b0;
        stop_bit = 1'b1;
        maj = 1'b0;
        nz = 1'b0;
        brk = 1'b0;
        nbits = `SRB_DATA_BITS + {3'h0, st_reg.ctrl.nine_mode} + {3'h0, st_reg.ctrl.par_en};
        st_next.rx_meta = rxd;
        st_next.rx_s = st_reg.rx_meta;
        st_next.xt_meta = crystal_clock;
        st_next.xt_s = st_reg.xt_meta;
        st_next.xt_d = st_reg.xt_s;
        st_next.src_meta = baud_clock_source_select;
        st_next.src_s = st_reg.src_meta;
        st_next.tx_load = 1'b0;

        // write channels, address and data in either order
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_ok = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_ok = 1'b1;
            st_next.wdata = s_axi_wdata[7:0];
            st_next.wlane = s_axi_wstrb[0];
        end
        if (st_reg.bvalid && s_axi_bready) st_next.bvalid = 1'b0;
        if (st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid) begin
            st_next.aw_ok = 1'b0;
            st_next.w_ok = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `SRB_RESP_OKAY;
            wsel = reg_sel(st_reg.awaddr);
            if (wsel == srb_pkg::SEL_NONE) begin
                st_next.bresp = `SRB_RESP_SLVERR;
            end else if (st_reg.wlane) begin
                if (wsel == srb_pkg::SEL_CTRL) begin
                    st_next.ctrl = srb_pkg::srb_ctrl_t'(st_reg.wdata[6:0]);
                end else if (wsel == srb_pkg::SEL_DATA) begin
                    st_next.tx_data = st_reg.wdata; // RULE_15
                    st_next.tx_load = 1'b1;
                end else if (wsel == srb_pkg::SEL_BAUD) begin
                    st_next.baud.prescale = st_reg.wdata[`SRB_BAUD_PRE_LSB +: 2];
                    st_next.baud.rate = st_reg.wdata[`SRB_BAUD_RATE_LSB +: 3];
                end
            end
        end
        st_next.awready = !st_next.aw_ok && !st_next.bvalid;
        st_next.wready = !st_next.w_ok && !st_next.bvalid;

        // read channel; status reads arm the clearing sequence
        if (st_reg.rvalid && s_axi_rready) st_next.rvalid = 1'b0;
        if (s_axi_arvalid && st_reg.arready) begin
            rsel = reg_sel(s_axi_araddr);
            st_next.rvalid = 1'b1;
            st_next.rresp = `SRB_RESP_OKAY;
            st_next.rdata = 8'h00;
            if (rsel == srb_pkg::SEL_CTRL) begin
                st_next.rdata = {st_reg.ninth, st_reg.ctrl};
            end else if (rsel == srb_pkg::SEL_ST1) begin
                st_next.rdata = {2'h0, st_reg.flags.receive_full_flag, 1'b0, st_reg.flags.ovr,
                                 st_reg.flags.nf, st_reg.flags.fe, st_reg.flags.pe};
                st_next.arm = st_reg.flags; // RULE_04 RULE_06
            end else if (rsel == srb_pkg::SEL_ST2) begin
                st_next.rdata = {6'h00, st_reg.break_flag, st_reg.reception_active_flag};
                st_next.bkf_arm = st_reg.break_flag; // RULE_11
            end else if (rsel == srb_pkg::SEL_DATA) begin
                st_next.rdata = st_reg.rx_data; // RULE_15
                data_rd = 1'b1; // RULE_21
            end else if (rsel == srb_pkg::SEL_BAUD) begin
                st_next.rdata = {2'h0, st_reg.baud.prescale, 1'b0, st_reg.baud.rate};
            end else begin
                st_next.rresp = `SRB_RESP_SLVERR;
            end
        end
        st_next.arready = !st_next.rvalid;

        // only flags seen set at the status read are cleared
        if (data_rd) begin
            st_next.flags = srb_pkg::srb_flags_t'(st_reg.flags & ~st_reg.arm); // RULE_04 RULE_05 RULE_06
            st_next.arm = srb_pkg::srb_flags_t'(`SRB_FLAGS_RST);
            if (st_reg.bkf_arm) st_next.break_flag = 1'b0; // RULE_11
            st_next.bkf_arm = 1'b0;
        end

        // receiver on the 16x sample tick
        if (rx16_tick) begin
            if (st_reg.rxs == srb_pkg::RX_SEARCH) begin
                if (st_reg.rx_s) begin
                    st_next.brk_block = 1'b0; // RULE_12
                    if (st_reg.idle_cnt != `SRB_IDLE_TICKS) begin
                        st_next.idle_cnt = st_reg.idle_cnt + 8'h01;
                    end
                    if (st_reg.idle_cnt == `SRB_IDLE_TICKS - 8'h01) st_next.reception_active_flag = 1'b0; // RULE_14
                end else begin
                    st_next.reception_active_flag = 1'b1; // RULE_13
                    st_next.rxs = srb_pkg::RX_START;
                    st_next.slot = 4'h1;
                    st_next.idle_cnt = 8'h00;
                end
            end else begin
                st_next.slot = st_reg.slot + 4'h1;
                if (st_reg.slot >= `SRB_SLOT_A && st_reg.slot <= `SRB_SLOT_C) begin
                    st_next.samp = {st_reg.samp[1:0], st_reg.rx_s};
                end
                maj = maj3(st_next.samp);
                nz = (|st_next.samp) && !(&st_next.samp);
                if (st_reg.slot == `SRB_SLOT_C) begin
                    case (st_reg.rxs)
                        srb_pkg::RX_START: begin
                            if (maj) begin
                                st_next.rxs = srb_pkg::RX_SEARCH;
                                st_next.reception_active_flag = 1'b0; // RULE_14
                            end else begin
                                st_next.noisy = nz;
                                st_next.anyone = 1'b0;
                                st_next.bit_idx = 4'h0;
                            end
                        end
                        srb_pkg::RX_DATA: begin
                            st_next.shreg[st_reg.bit_idx] = maj;
                            st_next.noisy = st_reg.noisy | nz;
                            st_next.anyone = st_reg.anyone | maj;
                        end
                        default: begin
                            frame_done = 1'b1;
                            stop_bit = maj;
                            st_next.rxs = srb_pkg::RX_SEARCH;
                        end
                    endcase
                end
                if (st_reg.slot == `SRB_SLOT_LAST) begin
                    if (st_reg.rxs == srb_pkg::RX_START) begin
                        st_next.rxs = srb_pkg::RX_DATA;
                    end else if (st_reg.rxs == srb_pkg::RX_DATA) begin
                        st_next.bit_idx = st_reg.bit_idx + 4'h1;
                        if (st_reg.bit_idx == nbits - 4'h1) st_next.rxs = srb_pkg::RX_STOP;
                    end
                end
            end
        end

        // frame end after the clears, so a new event wins over them
        if (frame_done) begin
            brk = !st_reg.anyone && !stop_bit;
            if (!stop_bit) st_next.flags.fe = 1'b1; // RULE_07
            if (st_reg.noisy || nz) st_next.flags.nf = 1'b1; // RULE_06
            if (st_reg.ctrl.par_en && par_bad(st_reg.shreg, nbits, st_reg.ctrl.par_odd)) begin
                st_next.flags.pe = 1'b1; // RULE_08
            end
            if (st_next.flags.receive_full_flag) begin
                st_next.flags.ovr = 1'b1; // RULE_01 RULE_02
            end else begin
                st_next.rx_data = st_reg.shreg[7:0];
                st_next.ninth = st_reg.ctrl.nine_mode ? (st_reg.shreg[8] && !brk) // RULE_24 RULE_10
                                                      : st_reg.shreg[7];
                st_next.flags.receive_full_flag = 1'b1; // RULE_23
            end
            if (brk) begin
                if (!st_reg.brk_block) st_next.break_flag = 1'b1; // RULE_10 RULE_12
                st_next.brk_block = 1'b1;
                st_next.flags.receive_full_flag = 1'b1;
            end
        end

        // break and reception flags stay out of the request
        st_next.irq = (st_next.flags.ovr && st_next.ctrl.overrun_irq_enable) // RULE_03 RULE_11 RULE_14
                   || (st_next.flags.nf && st_next.ctrl.noise_irq_enable)
                   || (st_next.flags.fe && st_next.ctrl.framing_irq_enable)
                   || (st_next.flags.pe && st_next.ctrl.parity_irq_enable);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.rx_data <= st_reg.rx_data; // RULE_15
            st_reg.ninth <= st_reg.ninth;
            st_reg.rx_meta <= 1'b1;
            st_reg.rx_s <= 1'b1;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
            st_reg.flags <= srb_pkg::srb_flags_t'(`SRB_FLAGS_RST); // RULE_09
            st_reg.ctrl <= srb_pkg::srb_ctrl_t'(`SRB_CTRL_RST);
            st_reg.baud <= srb_pkg::srb_baud_t'(`SRB_BAUD_RST); // RULE_20
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready  = st_reg.wready;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rdata   = {24'h000000, st_reg.rdata};
    assign s_axi_rresp   = st_reg.rresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign error_irq     = st_reg.irq;
    assign tx_data       = st_reg.tx_data;
    assign tx_load       = st_reg.tx_load;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_ovr; frame_done && st_reg.flags.receive_full_flag && !data_rd |=> st_reg.flags.ovr; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not flagged"); // RULE_01
    property p_keep; frame_done && st_reg.flags.receive_full_flag && !data_rd |=> $stable(st_reg.rx_data);
    endproperty
    a_keep: assert property (p_keep) else $error("buffer overwritten on overrun"); // RULE_02
    property p_irq;
        error_irq == ((st_reg.flags.ovr && st_reg.ctrl.overrun_irq_enable) || (st_reg.flags.nf && st_reg.ctrl.noise_irq_enable)
                   || (st_reg.flags.fe && st_reg.ctrl.framing_irq_enable) || (st_reg.flags.pe && st_reg.ctrl.parity_irq_enable));
    endproperty
    a_irq: assert property (p_irq) else $error("error request mismatch"); // RULE_03
    property p_clr; data_rd && st_reg.arm.ovr && !frame_done |=> !st_reg.flags.ovr; endproperty
    a_clr: assert property (p_clr) else $error("armed overrun not cleared"); // RULE_04
    property p_noarm; data_rd && !st_reg.arm.ovr && st_reg.flags.ovr |=> st_reg.flags.ovr;
    endproperty
    a_noarm: assert property (p_noarm) else $error("unarmed overrun cleared"); // RULE_05
    property p_fe; frame_done && !stop_bit |=> st_reg.flags.fe; endproperty
    a_fe: assert property (p_fe) else $error("framing error missed"); // RULE_07
    property p_bkf;
        frame_done && !stop_bit && !st_reg.anyone && !st_reg.brk_block
            |=> st_reg.break_flag && st_reg.flags.fe && st_reg.flags.receive_full_flag;
    endproperty
    a_bkf: assert property (p_bkf) else $error("break flags not set"); // RULE_10
    property p_rpf; rx16_tick && st_reg.rxs == srb_pkg::RX_SEARCH && !st_reg.rx_s |=> st_reg.reception_active_flag;
    endproperty
    a_rpf: assert property (p_rpf) else $error("reception active not set"); // RULE_13
    c_ovr: cover property (frame_done && st_reg.flags.receive_full_flag);
    c_brk: cover property (frame_done && !stop_bit && !st_reg.anyone);
    c_false: cover property (st_reg.rxs == srb_pkg::RX_START ##1 st_reg.rxs == srb_pkg::RX_SEARCH);
    c_clear: cover property (data_rd && st_reg.arm.ovr);
endmodule // srb_sci_rx
`default_nettype wire

// ---- srb_line_model.sv ----
// serial line model that sends frames into the receiver
`timescale 1ns/1ps
`default_nettype none
module srb_line_model (
    input  wire logic aclk,
    output logic      rxd
);
    initial rxd = 1'b1;
    // 64 cycles a bit: only valid while baud_select is 0x00
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        @(posedge aclk);
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (64) @(posedge aclk);
        end
        rxd <= 1'b1;
    endtask
endmodule // srb_line_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench of the serial receive status and baud block
`timescale 1ns/1ps
`default_nettype none
`include "srb_cfg.svh"
module testbench;
    logic        aclk = 1'b0, aresetn = 1'b0, rxd;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, tx_data;
    logic [31:0] wdata = 32'h0, rdata, v, g;
    logic [1:0]  rresp, r, bresp, b, xdiv = 2'h0;
    logic        awready, wready, bvalid, arready, rvalid, error_irq, tx_load, tx_bit_tick;
    logic        tl, xsel = 1'b0;
    int          n_errors = 0, tests_run = 0, cyc = 0;
    logic [19:0] rows [5] = '{20'h00040, 20'h100c0, 20'h20100, 20'h30340, 20'h03200};
    initial forever #20 aclk = ~aclk;
    srb_line_model u_srb_line_model (.aclk(aclk), .rxd(rxd));
    srb_sci_rx u_srb_sci_rx (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd(rxd),
        .crystal_clock(xdiv[1]), .baud_clock_source_select(xsel), .error_irq(error_irq),
        .tx_data(tx_data), .tx_load(tx_load), .tx_bit_tick(tx_bit_tick));
    task automatic wrap_up();
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        b = bresp;
        tl = tx_load;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        v = rdata;
        r = rresp;
    endtask
    // first gap may be partial, so the second one is kept
    task automatic tick_gap(output logic [31:0] n);
        repeat (2) begin
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while (tx_bit_tick !== 1'b1 && n < 4000);
        end
    endtask
    always @(posedge aclk) begin
        cyc++;
        // crystal stand-in at a quarter of the bus clock
        xdiv <= xdiv + 2'h1;
        if (cyc == 40000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`SRB_OFF_BAUD);
        chk(v, 32'h0);
        rd(`SRB_OFF_ST1);
        chk(v, 32'h0);
        foreach (rows[i]) begin
            wr(`SRB_OFF_BAUD, rows[i][19:12]);
            rd(`SRB_OFF_BAUD);
            chk(v, {24'h0, rows[i][19:12]});
            tick_gap(g);
            chk(g, {20'h0, rows[i][11:0]});
        end
        wr(`SRB_OFF_BAUD, 8'h00);
        rd(8'h04);
        chk(r, `SRB_RESP_SLVERR);
        wr(8'h04, 8'h00);
        chk(b, `SRB_RESP_SLVERR);
        wr(`SRB_OFF_CTRL, 8'h0f);
        wr(`SRB_OFF_DATA, 8'h3c);
        chk(tl, 1'b1);
        chk(tx_data, 8'h3c);
        u_srb_line_model.send(8'h5a, 1'b1);
        rd(`SRB_OFF_ST1);
        chk(v, 32'h20);
        rd(`SRB_OFF_ST2);
        chk(v, 32'h01);
        rd(`SRB_OFF_DATA);
        chk(v, 32'h5a);
        u_srb_line_model.send(8'h11, 1'b1);
        u_srb_line_model.send(8'h22, 1'b1);
        rd(`SRB_OFF_ST1);
        chk(v, 32'h28);
        chk(error_irq, 1'b1);
        rd(`SRB_OFF_DATA);
        chk(v, 32'h11);
        u_srb_line_model.send(8'h33, 1'b1);
        rd(`SRB_OFF_ST1);
        u_srb_line_model.send(8'h44, 1'b1);
        rd(`SRB_OFF_DATA);
        chk(v, 32'h33);
        rd(`SRB_OFF_ST1);
        chk(v, 32'h08);
        rd(`SRB_OFF_DATA);
        u_srb_line_model.send(8'h00, 1'b0);
        // ten high bit times let the idle detector drop reception active
        repeat (800) @(posedge aclk);
        rd(`SRB_OFF_ST2);
        chk(v, 32'h02);
        rd(`SRB_OFF_ST1);
        chk(v, 32'h22);
        rd(`SRB_OFF_DATA);
        rd(`SRB_OFF_ST2);
        chk(v, 32'h00);
        chk(error_irq, 1'b0);
        // parity rides in the model's stop slot; the idle line serves as stop
        wr(`SRB_OFF_CTRL, 8'h20);
        u_srb_line_model.send(8'h03, 1'b1);
        repeat (64) @(posedge aclk);
        rd(`SRB_OFF_ST1);
        chk(v, 32'h21);
        rd(`SRB_OFF_DATA);
        chk(v, 32'h03);
        // let the select pass its synchroniser before timing ticks
        xsel <= 1'b1;
        repeat (4) @(posedge aclk);
        tick_gap(g);
        chk(g, 32'h100);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
